// [pkg/remote_cmd_pkg.sv]
// constants, codes and carrier types for the remote command interpreter
// assumes an apb slave with 32-bit data and a 250 MHz pclk
package remote_cmd_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ERR = 8'h0C;
  localparam logic [7:0] REG_RESP0 = 8'h10;
  localparam logic [7:0] REG_RESP4 = 8'h20;
  localparam logic [7:0] REG_PUD_WR = 8'h24;
  localparam logic [7:0] REG_PUD_RD = 8'h28;
  localparam logic [7:0] REG_SETUP = 8'h2C;
  localparam logic [7:0] REG_SETUP_SAVED = 8'h30;
  localparam logic [7:0] REG_CONFIG = 8'h34;
  localparam logic [7:0] REG_DEFAULTS = 8'h38;
  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_AUX_LSB = 8;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int RST_HOLD_NS = 64;
  localparam int RST_CYCLES = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
  // storage
  localparam int PUD_MAX = 60;
  localparam int PUD_RESP_MAX = 64;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_TWO = 8'h32;
  localparam logic [7:0] CH_ZERO = 8'h30;
  // power-up defaults
  localparam logic [31:0] FLOAT_ZERO = 32'h0000_0000;
  localparam logic [9:0] DEF_VMARKER_LINE = 10'h00A;
  localparam logic [7:0] DEF_TRIG_LIM_S = 8'h0A;
  localparam logic [7:0] DEF_OVLD_LIM_S = 8'h0A;
  localparam logic [3:0] DEF_OUT_CHAN = 4'h1;
  localparam logic [3:0] DEF_TRIG_CHAN = 4'h5;
  localparam logic [7:0] SINE_JUMP_RATE_MHZ = 8'h01;
  // range name tokens, one class nibble per mode
  localparam logic [7:0] RANGE_PULSE_BASE = 8'h10;
  localparam logic [7:0] RANGE_MEASZ_BASE = 8'h20;
  localparam logic [7:0] RANGE_OVLD_BASE = 8'h30;
  localparam logic [2:0] PULSE_CODES = 3'h6;
  localparam logic [2:0] MEASZ_CODES = 3'h3;
  localparam logic [2:0] OVLD_CODES = 3'h2;
  // answer tokens
  localparam logic [31:0] TOK_Z50 = 32'h0000_0001;
  localparam logic [31:0] TOK_Z1M = 32'h0000_0002;
  localparam logic [31:0] TOK_OFF = 32'h0000_0000;
  localparam logic [31:0] TOK_ON = 32'h0000_0001;
  localparam logic [31:0] TOK_INT = 32'h0000_0001;
  localparam logic [31:0] TOK_EXT = 32'h0000_0002;

  typedef enum logic [7:0] {
    OP_NOP = 8'h00, OP_OUT_SET = 8'h01, OP_OUT_FREQ = 8'h02, OP_OUT_QUERY = 8'h03,
    OP_ERR_QUERY = 8'h04, OP_SHIFT = 8'h05, OP_IMP_SET = 8'h06, OP_IMP_QUERY = 8'h07,
    OP_PUD_STORE = 8'h08, OP_PUD_QUERY = 8'h09, OP_RANGE_SET = 8'h0A, OP_RANGE_QUERY = 8'h0B,
    OP_LOCK_SET = 8'h0C, OP_LOCK_QUERY = 8'h0D, OP_CLK_SET = 8'h0E, OP_CLK_QUERY = 8'h0F,
    OP_EDIT_REFERENCE_QUERY_QUERY = 8'h10, OP_NEW_REF = 8'h11, OP_SCALE_REF = 8'h12, OP_REMOTE = 8'h13,
    OP_LOCAL = 8'h14, OP_LOCKOUT = 8'h15, OP_RESET = 8'h16, OP_FUNC_SET = 8'h17,
    OP_SETUP_SAVE = 8'h18, OP_OPER = 8'h19
  } opcode_t;

  typedef enum logic [3:0] {
    FN_VOLT = 4'h0, FN_MARKER = 4'h1, FN_SVOLT = 4'h2, FN_EDGE = 4'h3, FN_LEVELED_SINE_MODE = 4'h4,
    FN_WAVEGEN = 4'h5, FN_VIDEO = 4'h6, FN_PULSE = 4'h7, FN_MEASZ = 4'h8, FN_OVERLD = 4'h9
  } func_t;

  typedef enum logic [3:0] {
    UNIT_ZERO = 4'h0, UNIT_V = 4'h1, UNIT_A = 4'h2, UNIT_OHM = 4'h3,
    UNIT_PPM = 4'h4, UNIT_PCT = 4'h5, UNIT_DB = 4'h6
  } unit_t;

  typedef enum logic [3:0] {
    FORM_DEFINITE = 4'h0, FORM_INDEFINITE = 4'h1, FORM_STRING = 4'h2
  } pud_form_t;

  typedef enum logic [7:0] {
    ERR_NONE = 8'h00, ERR_BAD_PARAM = 8'h01, ERR_MODE = 8'h02, ERR_CAL_LOCKED = 8'h03,
    ERR_PUD_LEN = 8'h04, ERR_BAD_OP = 8'h05
  } err_t;

  typedef enum logic [1:0] {
    EX_IDLE = 2'b00, EX_RESETTING = 2'b01
  } exec_t;

  // front panel facing state
  typedef struct packed {
    logic remote;
    logic lockout;
    logic standby;
    logic busy;
    logic scope_on;
    logic imp_fifty;
    logic range_frozen;
    logic timebase_ext;
    logic sine_jump;
  } panel_t;
endpackage : remote_cmd_pkg

// [src/remote_cmd.sv]
// remote command interpreter with apb register access
// assumes synchronous inputs on pclk; cal_enable is the calibration switch level
//
// Summary of operation
// - output query returns amplitudes, units, frequency fields
// - error query gives magnitude and unit while editing
// - impedance choice 50 ohm or 1 megohm, scope volt only
// - impedance query returns present selection token
// - protected data stored only with calibration switch enabled
// - definite, indefinite or quoted forms accepted; definite form needs arg length equal to staged count
// - protected data readback as block, at most 64 characters
// - pulse mode accepts six amplitude range codes
// - measure three codes, overload two codes
// - range query returns first range, second zero
// - range lock flag shown as range_frozen, range set not blocked; cleared on function change
// - lock query returns on or off
// - timebase source internal or external, kept, queryable
// - reference query returns captured reference, else zero
// - remote command enters remote; lockout kept
// - reset holds off later commands until done
// - reset applies power-up defaults
// - reset discards unsaved setup changes
// - reset puts leveled sine into jump mode
// - local clears remote and front panel lockout
`timescale 1ns/100ps
module remote_cmd (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cal_enable,
  output remote_cmd_pkg::panel_t panel
);
  import remote_cmd_pkg::*;

  typedef struct packed {
    exec_t ex;
    logic [4:0] busy_cnt;
    logic [7:0] last_cmd;
    logic [31:0] arg;
    err_t err;
    logic [4:0][31:0] resp;
    func_t func;
    logic [2:0] range;
    logic imp_fifty;
    logic lock;
    logic clk_ext;
    logic standby;
    logic [31:0] amp;
    logic [31:0] freq;
    logic [31:0] dc_offset;
    logic video_ntsc;
    logic [9:0] vmarker_line;
    logic trig_on;
    logic [7:0] trig_lim;
    logic [7:0] ovld_lim;
    logic [3:0] out_chan;
    logic [3:0] trig_chan;
    logic sine_jump;
    logic editing;
    logic [31:0] ref_amp;
    logic [31:0] err_mag;
    unit_t err_unit;
    logic remote;
    logic lockout;
    logic [15:0] setup_pend;
    logic [15:0] setup_saved;
    logic [PUD_MAX-1:0][7:0] stage;
    logic [5:0] stage_len;
    logic [PUD_MAX-1:0][7:0] nv;
    logic [5:0] nv_len;
    logic [6:0] rd_ptr;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  localparam state_t STATE_RST = '0;
  localparam logic [4:0] RST_COUNT = 5'(RST_CYCLES);
  localparam logic [6:0] HDR_LEN = 7'h04;

  logic acc;
  logic wr;
  logic rd;
  logic cmd_stall;
  logic [7:0] op;
  logic [3:0] aux;
  logic [6:0] blk_total;
  logic [7:0] rd_byte;
  logic [7:0] tens;
  logic [7:0] ones;
  logic voltage_edit;
  logic mapped;

  // decimal split of a length up to 60
  function automatic logic [7:0] div10(input logic [5:0] n);
    logic [7:0] q;
    q = 8'h00;
    for (int k = 1; k <= 6; k++) begin
      if (n >= 6'(10 * k)) begin
        q = 8'(k);
      end
    end
    return q;
  endfunction : div10

  // restore power-up values; nonvolatile items and remote state survive
  function automatic state_t apply_defaults(input state_t a);
    state_t b;
    b = a;
    b.standby = 1'b1;
    b.amp = FLOAT_ZERO;
    b.freq = FLOAT_ZERO;
    b.dc_offset = FLOAT_ZERO;
    b.video_ntsc = 1'b1;
    b.vmarker_line = DEF_VMARKER_LINE;
    b.trig_on = 1'b0;
    b.trig_lim = DEF_TRIG_LIM_S;
    b.ovld_lim = DEF_OVLD_LIM_S;
    b.out_chan = DEF_OUT_CHAN;
    b.trig_chan = DEF_TRIG_CHAN;
    b.lock = 1'b0;
    b.func = FN_VOLT;
    b.imp_fifty = 1'b0;
    b.range = 3'h0;
    b.editing = 1'b0;
    b.ref_amp = FLOAT_ZERO;
    b.err_mag = FLOAT_ZERO;
    b.err_unit = UNIT_ZERO;
    b.setup_pend = a.setup_saved;
    b.sine_jump = 1'b1;
    return b;
  endfunction : apply_defaults

  assign acc = psel && penable;
  assign op = pwdata[CMD_OP_LSB +: 8];
  assign aux = pwdata[CMD_AUX_LSB +: 4];
  // commands wait in the access phase while a reset is still running
  assign cmd_stall = (s_r.ex == EX_RESETTING) && pwrite && (paddr == REG_CMD);
  assign wr = acc && pwrite && !cmd_stall;
  assign rd = acc && !pwrite;
  assign blk_total = HDR_LEN + 7'(s_r.nv_len);
  assign tens = div10(s_r.nv_len);
  assign ones = 8'(s_r.nv_len) - 8'(tens * 8'h0A);
  assign voltage_edit = s_r.editing && (s_r.func == FN_VOLT || s_r.func == FN_MARKER);

  always_comb begin
    unique case (s_r.rd_ptr)
      7'h00: rd_byte = CH_HASH;
      7'h01: rd_byte = CH_TWO;
      7'h02: rd_byte = CH_ZERO + tens;
      7'h03: rd_byte = CH_ZERO + ones;
      default: rd_byte = (s_r.rd_ptr < blk_total) ? s_r.nv[6'(s_r.rd_ptr - HDR_LEN)] : 8'h00;
    endcase
  end

  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      REG_CMD: prdata = {24'h00_0000, s_r.last_cmd};
      REG_ARG: prdata = s_r.arg;
      REG_STATUS: prdata = {18'h0_0000, s_r.editing, s_r.sine_jump, s_r.lock, s_r.clk_ext,
                            s_r.imp_fifty, s_r.standby, cal_enable, (s_r.err != ERR_NONE),
                            s_r.lockout, s_r.remote, (s_r.ex == EX_RESETTING), 1'b0, 2'b00};
      REG_ERR: prdata = {24'h00_0000, s_r.err};
      REG_PUD_WR: prdata = {26'h000_0000, s_r.stage_len};
      REG_PUD_RD: prdata = {24'h00_0000, rd_byte};
      REG_SETUP: prdata = {16'h0000, s_r.setup_pend};
      REG_SETUP_SAVED: prdata = {16'h0000, s_r.setup_saved};
      REG_CONFIG: prdata = {16'h0000, s_r.out_chan, s_r.trig_chan, 1'b0, s_r.range, s_r.func};
      REG_DEFAULTS: prdata = {s_r.trig_lim, s_r.ovld_lim, SINE_JUMP_RATE_MHZ, s_r.trig_on,
                              s_r.video_ntsc, s_r.vmarker_line[5:0]};
      default: begin
        if (paddr >= REG_RESP0 && paddr <= REG_RESP4 && paddr[1:0] == 2'b00) begin
          prdata = s_r.resp[3'((paddr - REG_RESP0) >> 2)];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  assign pready = !cmd_stall;
  assign pslverr = acc && !cmd_stall && !mapped;

  always_comb begin
    s_nxt = s_r;
    // reset hold-off countdown
    if (s_r.ex == EX_RESETTING) begin
      if (s_r.busy_cnt <= 5'h01) begin
        s_nxt.ex = EX_IDLE;
        s_nxt.busy_cnt = 5'h00;
      end else begin
        s_nxt.busy_cnt = s_r.busy_cnt - 5'h01;
      end
    end
    // protected block readback walks one byte per read
    if (rd && paddr == REG_PUD_RD && s_r.rd_ptr < blk_total) begin
      s_nxt.rd_ptr = s_r.rd_ptr + 7'h01;
    end
    // error clear first so a same-cycle command error still lands
    if (wr && paddr == REG_ERR) begin
      s_nxt.err = ERR_NONE;
    end
    if (wr && paddr == REG_ARG) begin
      s_nxt.arg = pwdata;
    end
    if (wr && paddr == REG_SETUP) begin
      s_nxt.setup_pend = pwdata[15:0];
    end
    if (wr && paddr == REG_PUD_WR) begin
      if (s_r.stage_len < 6'(PUD_MAX)) begin
        s_nxt.stage[s_r.stage_len] = pwdata[7:0];
        s_nxt.stage_len = s_r.stage_len + 6'h01;
      end else begin
        s_nxt.err = ERR_PUD_LEN;
      end
    end
    if (wr && paddr == REG_CMD) begin
      s_nxt.last_cmd = op;
      unique case (op)
        OP_NOP: begin
        end
        OP_OUT_SET: begin
          s_nxt.amp = s_r.arg;
          s_nxt.ref_amp = s_r.arg;
          s_nxt.editing = 1'b0;
        end
        OP_OUT_FREQ: s_nxt.freq = s_r.arg;
        OP_OPER: s_nxt.standby = aux[0] ? 1'b0 : 1'b1;
        OP_OUT_QUERY: begin
          // fields are raw float words, no scale letters
          s_nxt.resp[0] = s_r.amp;
          s_nxt.resp[1] = {28'h000_0000, (s_r.func == FN_MEASZ) ? UNIT_OHM : UNIT_V};
          s_nxt.resp[2] = FLOAT_ZERO;
          s_nxt.resp[3] = {28'h000_0000, UNIT_ZERO};
          s_nxt.resp[4] = s_r.freq;
        end
        OP_SHIFT: begin
          if (!(s_r.func == FN_VOLT || s_r.func == FN_MARKER)) begin
            s_nxt.err = ERR_MODE;
          end else if (aux == UNIT_PPM || aux == UNIT_PCT || aux == UNIT_DB) begin
            s_nxt.editing = 1'b1;
            s_nxt.err_mag = s_r.arg;
            s_nxt.err_unit = unit_t'(aux);
          end else begin
            s_nxt.err = ERR_BAD_PARAM;
          end
        end
        OP_ERR_QUERY: begin
          s_nxt.resp[0] = voltage_edit ? s_r.err_mag : FLOAT_ZERO;
          s_nxt.resp[1] = {28'h000_0000, voltage_edit ? s_r.err_unit : UNIT_ZERO};
        end
        OP_IMP_SET: begin
          if (s_r.func != FN_SVOLT) begin
            s_nxt.err = ERR_MODE;
          end else if (aux <= 4'h1) begin
            s_nxt.imp_fifty = aux[0];
          end else begin
            s_nxt.err = ERR_BAD_PARAM;
          end
        end
        OP_IMP_QUERY: s_nxt.resp[0] = s_r.imp_fifty ? TOK_Z50 : TOK_Z1M;
        OP_PUD_STORE: begin
          if (!cal_enable) begin
            s_nxt.err = ERR_CAL_LOCKED;
          end else if (aux > FORM_STRING) begin
            s_nxt.err = ERR_BAD_PARAM;
          end else if (aux == FORM_DEFINITE && s_r.arg[7:0] != 8'(s_r.stage_len)) begin
            s_nxt.err = ERR_PUD_LEN;
          end else begin
            s_nxt.nv = s_r.stage;
            s_nxt.nv_len = s_r.stage_len;
            s_nxt.stage_len = 6'h00;
          end
        end
        OP_PUD_QUERY: begin
          s_nxt.rd_ptr = 7'h00;
          s_nxt.resp[0] = {25'h000_0000, blk_total};
        end
        OP_RANGE_SET: begin
          unique case (s_r.func)
            FN_PULSE: begin
              if (s_r.arg[2:0] < PULSE_CODES && s_r.arg[31:3] == 29'h0) begin
                s_nxt.range = s_r.arg[2:0];
              end else begin
                s_nxt.err = ERR_BAD_PARAM;
              end
            end
            FN_MEASZ: begin
              if (s_r.arg[2:0] < MEASZ_CODES && s_r.arg[31:3] == 29'h0) begin
                s_nxt.range = s_r.arg[2:0];
              end else begin
                s_nxt.err = ERR_BAD_PARAM;
              end
            end
            FN_OVERLD: begin
              if (s_r.arg[2:0] < OVLD_CODES && s_r.arg[31:3] == 29'h0) begin
                s_nxt.range = s_r.arg[2:0];
              end else begin
                s_nxt.err = ERR_BAD_PARAM;
              end
            end
            default: s_nxt.err = ERR_MODE;
          endcase
        end
        OP_RANGE_QUERY: begin
          unique case (s_r.func)
            FN_PULSE: s_nxt.resp[0] = {24'h00_0000, RANGE_PULSE_BASE + 8'(s_r.range)};
            FN_MEASZ: s_nxt.resp[0] = {24'h00_0000, RANGE_MEASZ_BASE + 8'(s_r.range)};
            FN_OVERLD: s_nxt.resp[0] = {24'h00_0000, RANGE_OVLD_BASE + 8'(s_r.range)};
            default: s_nxt.resp[0] = 32'h0000_0000;
          endcase
          s_nxt.resp[1] = 32'h0000_0000;
        end
        OP_LOCK_SET: begin
          if (aux <= 4'h1) begin
            s_nxt.lock = aux[0];
          end else begin
            s_nxt.err = ERR_BAD_PARAM;
          end
        end
        OP_LOCK_QUERY: s_nxt.resp[0] = s_r.lock ? TOK_ON : TOK_OFF;
        OP_CLK_SET: begin
          if (aux <= 4'h1) begin
            s_nxt.clk_ext = aux[0];
          end else begin
            s_nxt.err = ERR_BAD_PARAM;
          end
        end
        OP_CLK_QUERY: s_nxt.resp[0] = s_r.clk_ext ? TOK_EXT : TOK_INT;
        OP_EDIT_REFERENCE_QUERY_QUERY: s_nxt.resp[0] = voltage_edit ? s_r.ref_amp : FLOAT_ZERO;
        OP_NEW_REF: begin
          s_nxt.ref_amp = s_r.amp;
          s_nxt.editing = 1'b0;
        end
        OP_SCALE_REF: begin
          // argument carries the already scaled amplitude; no float multiplier here
          s_nxt.amp = s_r.arg;
          s_nxt.ref_amp = s_r.arg;
        end
        OP_REMOTE: s_nxt.remote = 1'b1;
        OP_LOCKOUT: begin
          if (s_r.remote) begin
            s_nxt.lockout = 1'b1;
          end else begin
            s_nxt.err = ERR_MODE;
          end
        end
        OP_LOCAL: begin
          s_nxt.remote = 1'b0;
          s_nxt.lockout = 1'b0;
        end
        OP_FUNC_SET: begin
          if (aux <= FN_OVERLD) begin
            s_nxt.func = func_t'(aux);
            s_nxt.range = 3'h0;
            s_nxt.editing = 1'b0;
            if (func_t'(aux) != s_r.func) begin
              s_nxt.lock = 1'b0;
            end
          end else begin
            s_nxt.err = ERR_BAD_PARAM;
          end
        end
        OP_SETUP_SAVE: s_nxt.setup_saved = s_r.setup_pend;
        OP_RESET: begin
          // lockout is left alone: only local or power loss clears it
          s_nxt = apply_defaults(s_nxt);
          s_nxt.ex = EX_RESETTING;
          s_nxt.busy_cnt = RST_COUNT;
        end
        default: s_nxt.err = ERR_BAD_OP;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= STATE_RST;
      s_r.standby <= 1'b1;
      s_r.video_ntsc <= 1'b1;
      s_r.vmarker_line <= DEF_VMARKER_LINE;
      s_r.trig_lim <= DEF_TRIG_LIM_S;
      s_r.ovld_lim <= DEF_OVLD_LIM_S;
      s_r.out_chan <= DEF_OUT_CHAN;
      s_r.trig_chan <= DEF_TRIG_CHAN;
      s_r.sine_jump <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign panel = '{remote: s_r.remote, lockout: s_r.lockout, standby: s_r.standby,
                   busy: (s_r.ex == EX_RESETTING), scope_on: (s_r.func >= FN_SVOLT),
                   imp_fifty: s_r.imp_fifty, range_frozen: s_r.lock, timebase_ext: s_r.clk_ext,
                   sine_jump: s_r.sine_jump};
endmodule : remote_cmd

// [testbench/remote_cmd_props.sv]
// port assertions for the remote command interpreter
// assumes one pclk domain, bound onto remote_cmd
`timescale 1ns/100ps
module remote_cmd_props
  import remote_cmd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cal_enable,
  input wire remote_cmd_pkg::panel_t panel
);
  logic [7:0] busy_cnt_r;
  logic cmd_wr;
  assign cmd_wr = psel && penable && pready && pwrite && (paddr == REG_CMD);
  // counts whole hold-off, too long for a repetition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_r <= 8'h00;
    end else begin
      busy_cnt_r <= panel.busy ? busy_cnt_r + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_HOLD_OFF: assert property (psel && penable && pwrite && paddr == REG_CMD && panel.busy |-> !pready)
    else $error("command accepted during reset hold-off");
  AST_HOLD_LEN: assert property ($fell(panel.busy) |-> busy_cnt_r == RST_CYCLES)
    else $error("reset hold-off length wrong");
  AST_NO_WAIT: assert property (psel && penable && !(pwrite && paddr == REG_CMD) |-> pready)
    else $error("access stalled outside hold-off");
  AST_BUSY_ENTRY: assert property (cmd_wr && pwdata[7:0] == OP_RESET |=> panel.busy)
    else $error("reset command did not start hold-off");
  AST_RST_DEFAULTS: assert property ($fell(panel.busy) |-> panel.standby && panel.sine_jump && !panel.range_frozen && !panel.imp_fifty && !panel.scope_on)
    else $error("defaults missing after reset");
  AST_REMOTE_SET: assert property (cmd_wr && pwdata[7:0] == OP_REMOTE |=> panel.remote)
    else $error("remote not entered");
  AST_LOCKOUT_KEPT: assert property (panel.lockout && !(cmd_wr && pwdata[7:0] == OP_LOCAL) |=> panel.lockout)
    else $error("lockout dropped without local");
  AST_LOCAL_CLR: assert property (cmd_wr && pwdata[7:0] == OP_LOCAL |=> !panel.remote && !panel.lockout)
    else $error("local left remote or lockout");
  AST_LOCK_FUNC: assert property ($changed(panel.scope_on) |-> !panel.range_frozen)
    else $error("range lock kept over function change");
  AST_IMP_SCOPE: assert property ($rose(panel.imp_fifty) |-> $past(panel.scope_on))
    else $error("impedance changed outside scope mode");
  AST_CAL_SEEN: assert property (psel && penable && !pwrite && paddr == REG_STATUS |-> prdata[7] == cal_enable)
    else $error("switch level not reported");
endmodule : remote_cmd_props

bind remote_cmd remote_cmd_props remote_cmd_props_inst (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .cal_enable(cal_enable),
  .panel(panel)
);

// [testbench/host_apb_master.sv]
// host model issuing one apb transfer per call
// assumes pready sampled at rising pclk
`timescale 1ns/100ps
module host_apb_master (
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // request held until pready seen high at a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer
endmodule : host_apb_master

// [testbench/remote_cmd_tb_top.sv]
// self-checking bench for the remote command interpreter
// assumes host model drives apb, checker bound to design
`timescale 1ns/100ps
module remote_cmd_tb_top;
  import remote_cmd_pkg::*;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
  } note_t;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cal_enable;
  panel_t panel;
  note_t notes[$];
  int errors = 0;
  int check_count = 0;
  integer seed = 71;
  int i;
  int j;
  int k;
  logic [7:0] pb [16];
  logic [31:0] amp;
  logic [7:0] base [3];
  logic [2:0] cnt [3];
  func_t fn [3];
  remote_cmd remote_cmd_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cal_enable(cal_enable), .panel(panel));
  host_apb_master host_apb_master_inst (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task test_done;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #40000;
    errors++;
    test_done;
  end
  // read results judged where they appear, oldest note first
  always @(posedge pclk) begin : watch
    note_t n;
    if (psel && penable && pready && !pwrite) begin
      n = notes.pop_front();
      check_count++;
      if (((prdata & n.m) !== (n.d & n.m)) || (pslverr !== n.e)) begin
        errors++;
        $display("MISMATCH read %h expected %h/%b seen %h/%b", paddr, n.d, n.e, prdata, pslverr);
      end
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    host_apb_master_inst.xfer(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hFFFF_FFFF);
    notes.push_back('{d, m, 1'b0});
    host_apb_master_inst.xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  task bad(input logic [7:0] a);
    notes.push_back('{32'h0000_0000, 32'h0000_0000, 1'b1});
    host_apb_master_inst.xfer(1'b0, a, 32'h0000_0000);
  endtask : bad
  task cmd(input logic [7:0] op, input logic [3:0] aux);
    wr(REG_CMD, {20'h00000, aux, op});
  endtask : cmd
  task ask(input logic [7:0] op, input logic [31:0] d);
    cmd(op, 4'h0);
    rd(REG_RESP0, d);
  endtask : ask
  task err_is(input logic [7:0] e);
    rd(REG_ERR, {24'h000000, e});
    wr(REG_ERR, 32'h0000_0000);
  endtask : err_is
  task chkp(input logic [8:0] e, input logic [8:0] m);
    @(negedge pclk);
    check_count++;
    if ((panel & m) !== (e & m)) begin
      errors++;
      $display("MISMATCH panel expected %h seen %h", e & m, panel & m);
    end
  endtask : chkp
  initial begin
    presetn = 1'b0;
    cal_enable = 1'b0;
    fn = '{FN_PULSE, FN_MEASZ, FN_OVERLD};
    base = '{RANGE_PULSE_BASE, RANGE_MEASZ_BASE, RANGE_OVLD_BASE};
    cnt = '{PULSE_CODES, MEASZ_CODES, OVLD_CODES};
    repeat (3) @(posedge pclk);
    chkp(9'h041, 9'h1FF);
    @(posedge pclk);
    presetn <= 1'b1;
    rd(REG_STATUS, 32'h0000_1100);
    rd(REG_CONFIG, 32'h0000_1500);
    rd(REG_DEFAULTS, 32'h0A0A_014A);
    bad(8'h3C);
    bad(8'h11);
    amp = $random(seed);
    wr(REG_ARG, amp);
    cmd(OP_OUT_SET, 4'h0);
    ask(OP_OUT_QUERY, amp);
    rd(REG_RESP0 + 8'h04, {28'h0000000, UNIT_V});
    rd(REG_RESP0 + 8'h08, 32'h0000_0000);
    rd(REG_RESP0 + 8'h0C, {28'h0000000, UNIT_ZERO});
    rd(REG_RESP4, 32'h0000_0000);
    ask(OP_EDIT_REFERENCE_QUERY_QUERY, 32'h0000_0000);
    for (i = 4; i < 7; i++) begin
      wr(REG_ARG, amp ^ 32'(i));
      cmd(OP_SHIFT, 4'(i));
      ask(OP_ERR_QUERY, amp ^ 32'(i));
      rd(REG_RESP0 + 8'h04, 32'(i));
    end
    ask(OP_EDIT_REFERENCE_QUERY_QUERY, amp);
    wr(REG_ARG, ~amp);
    cmd(OP_SCALE_REF, 4'h0);
    ask(OP_EDIT_REFERENCE_QUERY_QUERY, ~amp);
    cmd(OP_NEW_REF, 4'h0);
    ask(OP_EDIT_REFERENCE_QUERY_QUERY, 32'h0000_0000);
    ask(OP_ERR_QUERY, 32'h0000_0000);
    cmd(OP_OUT_FREQ, 4'h0);
    ask(OP_OUT_QUERY, ~amp);
    rd(REG_RESP4, ~amp);
    cmd(8'h1A, 4'h0);
    err_is(ERR_BAD_OP);
    cmd(OP_IMP_SET, 4'h1);
    err_is(ERR_MODE);
    ask(OP_IMP_QUERY, TOK_Z1M);
    cmd(OP_FUNC_SET, FN_SVOLT);
    cmd(OP_IMP_SET, 4'h1);
    ask(OP_IMP_QUERY, TOK_Z50);
    chkp(9'h018, 9'h018);
    cmd(OP_SHIFT, 4'h4);
    err_is(ERR_MODE);
    for (i = 0; i < 3; i++) begin
      cmd(OP_FUNC_SET, fn[i]);
      for (j = 0; j <= cnt[i]; j++) begin
        wr(REG_ARG, 32'(j));
        cmd(OP_RANGE_SET, 4'h0);
        k = (j < cnt[i]) ? j : cnt[i] - 1;
        ask(OP_RANGE_QUERY, {24'h000000, base[i] + 8'(k)});
        if (j == cnt[i]) begin
          err_is(ERR_BAD_PARAM);
        end
      end
      rd(REG_RESP0 + 8'h04, 32'h0000_0000);
    end
    cmd(OP_LOCK_SET, 4'h1);
    ask(OP_LOCK_QUERY, TOK_ON);
    chkp(9'h004, 9'h004);
    cmd(OP_FUNC_SET, FN_VOLT);
    ask(OP_LOCK_QUERY, TOK_OFF);
    cal_enable <= 1'b1;
    for (i = 0; i < 3; i++) begin
      j = 4 + 3 * i;
      for (k = 0; k < j; k++) begin
        pb[k] = 8'($random(seed));
        wr(REG_PUD_WR, {24'h000000, pb[k]});
      end
      wr(REG_ARG, 32'(j));
      cmd(OP_PUD_STORE, 4'(i));
      ask(OP_PUD_QUERY, 32'(j + 4));
      rd(REG_PUD_RD, {24'h000000, CH_HASH});
      rd(REG_PUD_RD, {24'h000000, CH_TWO});
      rd(REG_PUD_RD, {24'h000000, CH_ZERO + 8'(j / 10)});
      rd(REG_PUD_RD, {24'h000000, CH_ZERO + 8'(j % 10)});
      for (k = 0; k < j; k++) begin
        rd(REG_PUD_RD, {24'h000000, pb[k]});
      end
      rd(REG_PUD_RD, 32'h0000_0000);
    end
    for (k = 0; k < PUD_MAX + 1; k++) begin
      wr(REG_PUD_WR, 32'($random(seed)) & 32'h0000_00FF);
    end
    err_is(ERR_PUD_LEN);
    cal_enable <= 1'b0;
    cmd(OP_PUD_STORE, 4'h1);
    err_is(ERR_CAL_LOCKED);
    ask(OP_PUD_QUERY, 32'h0000_000E);
    cmd(OP_CLK_SET, 4'h1);
    cmd(OP_REMOTE, 4'h0);
    cmd(OP_LOCKOUT, 4'h0);
    wr(REG_SETUP, 32'h0000_1234);
    cmd(OP_SETUP_SAVE, 4'h0);
    wr(REG_SETUP, 32'h0000_5678);
    cmd(OP_FUNC_SET, FN_PULSE);
    cmd(OP_OPER, 4'h1);
    cmd(OP_RESET, 4'h0);
    rd(REG_STATUS, 32'h0000_0008, 32'h0000_0008);
    ask(OP_CLK_QUERY, TOK_EXT);
    rd(REG_SETUP, 32'h0000_1234);
    rd(REG_CONFIG, 32'h0000_1500);
    chkp(9'h1C3, 9'h1E3);
    cmd(OP_LOCAL, 4'h0);
    chkp(9'h000, 9'h180);
    test_done;
  end
endmodule : remote_cmd_tb_top
